// >>> reset_seq_map.vh
// Register map and timing constants of the reset time-out sequencer
`ifndef RESET_SEQ_MAP_VH
`define RESET_SEQ_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
// Power control is kept as a word index; its byte address is four times it
`define PWRCTL_INDEX      12'h08E
`define PWRCTL_OFFSET     (`PWRCTL_INDEX << 2)
`define SEQCFG_OFFSET     12'h090
`define SEQSTAT_OFFSET    12'h094

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWRCTL_BROWN_BIT  0
`define PWRCTL_POWER_BIT  1
`define CFG_DELAYEN_BIT   0
`define CFG_BOREN_LSB     1
`define CFG_BOREN_MSB     2
`define CFG_EXTCLK_BIT    3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SEQCFG_RESET      4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
// Plain defaults in clock cycles; set per product
`define DELAY_CYCLES      16'h1000
`define OSC_START_CYCLES  16'h0200

`endif

// >>> reset_timeout_sequencer.v
// Reset time-out sequencer with power control register on APB
//
// Contract
// - Power-up delay timer starts only after the power-on pulse ends or after a brown-out event.
// - Oscillator start-up timer starts after the power-up delay finishes, or after the power-on pulse when the delay is disabled; external clock mode skips it.
// - External clock mode with power-up delay disabled gives no time-out.
// - Chain timed from power-on pulse; late pin release starts at once.
// - Power control register at 8Eh holds two reset-cause bits.
// - Brown-out flag clears on brown-out reset; software sets it.
// - Brown-out flag meaningless when brown-out enable field is 00.
// - Power-on flag cleared by power-on reset only; software writes one. The code also clears it on rst_b.
`timescale 1ns/1ns
`include "reset_seq_map.vh"

module reset_timeout_sequencer
#(
  parameter DELAY_CYCLES = `DELAY_CYCLES,
  parameter OSC_CYCLES   = `OSC_START_CYCLES
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // Reset sources and straps
  input  wire        powerOnPulse,
  input  wire        brownoutPulse,
  input  wire        extResetPin_b,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Sequencer outputs
  output reg         internalReset,
  output wire        seqBusy
);

  // ----------------------------------------
  // Local definitions
  // ----------------------------------------
  localparam [1:0] ST_POR   = 2'h0;
  localparam [1:0] ST_DELAY = 2'h1;
  localparam [1:0] ST_OSC   = 2'h2;
  localparam [1:0] ST_DONE  = 2'h3;

  // Three-stage synchroniser, stable when stages two and three agree
  reg  [2:0]  porSync_r;
  reg  [2:0]  borSync_r;
  reg  [2:0]  pinSync_r;
  reg         porLvl_r;
  reg         borLvl_r;
  reg         pinLvl_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [20:0] count_r;
  reg  [20:0] count_nxt;
  reg  [3:0]  cfg_r;
  reg         powerFlag_r;
  reg         brownFlag_r;
  reg         borPrev_r;

  wire        delayEn;
  wire        extClk;
  wire [1:0]  borEn;
  wire        access;
  wire        borEvent;

  assign delayEn = cfg_r[`CFG_DELAYEN_BIT];
  assign extClk  = cfg_r[`CFG_EXTCLK_BIT];
  assign borEn   = cfg_r[`CFG_BOREN_MSB:`CFG_BOREN_LSB];
  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign seqBusy = (state_r != ST_DONE);
  assign borEvent = borLvl_r & ~borPrev_r & (borEn != 2'h0);

  // Address match helper
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      porSync_r <= 3'h7;
      borSync_r <= 3'h0;
      pinSync_r <= 3'h0;
      porLvl_r  <= 1'b1;
      borLvl_r  <= 1'b0;
      pinLvl_r  <= 1'b0;
      borPrev_r <= 1'b0;
    end
    else
    begin
      porSync_r <= {porSync_r[1:0], powerOnPulse};
      borSync_r <= {borSync_r[1:0], brownoutPulse};
      pinSync_r <= {pinSync_r[1:0], extResetPin_b};
      if (porSync_r[1] == porSync_r[2])
        porLvl_r <= porSync_r[2];
      if (borSync_r[1] == borSync_r[2])
        borLvl_r <= borSync_r[2];
      if (pinSync_r[1] == pinSync_r[2])
        pinLvl_r <= pinSync_r[2];
      borPrev_r <= borLvl_r;
    end
  end

  // ----------------------------------------
  // Time-out chain
  // ----------------------------------------
  always @*
  begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      ST_POR:
        if (!porLvl_r)
        begin
          count_nxt = 21'h000000;
          if (delayEn)
            state_nxt = ST_DELAY;
          else if (extClk)
            state_nxt = ST_DONE;
          else
            state_nxt = ST_OSC;
        end
      ST_DELAY:
        if (count_r == DELAY_CYCLES - 1)
        begin
          count_nxt = 21'h000000;
          state_nxt = extClk ? ST_DONE : ST_OSC;
        end
        else
          count_nxt = count_r + 21'h000001;
      ST_OSC:
        if (count_r == OSC_CYCLES - 1)
          state_nxt = ST_DONE;
        else
          count_nxt = count_r + 21'h000001;
      ST_DONE:
        state_nxt = ST_DONE;
      default:
        state_nxt = ST_POR;
    endcase
    if (porLvl_r || borEvent)
      state_nxt = ST_POR;
  end

  // State and internal reset registers
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r       <= ST_POR;
      count_r       <= 21'h000000;
      internalReset <= 1'b1;
    end
    else
    begin
      state_r       <= state_nxt;
      count_r       <= count_nxt;
      internalReset <= (state_nxt != ST_DONE) | ~pinLvl_r;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg_r       <= `SEQCFG_RESET;
      powerFlag_r <= 1'b0;
      brownFlag_r <= 1'b0; // Cleared at reset; software sets it
    end
    else
    begin
      if (access && pwrite && hit(paddr, `SEQCFG_OFFSET))
        cfg_r <= pwdata[3:0];
      if (porLvl_r)
        powerFlag_r <= 1'b0;
      else if (access && pwrite && hit(paddr, `PWRCTL_OFFSET))
        powerFlag_r <= pwdata[`PWRCTL_POWER_BIT];
      if (borEvent)
        brownFlag_r <= 1'b0;
      else if (access && pwrite && hit(paddr, `PWRCTL_OFFSET))
        brownFlag_r <= pwdata[`PWRCTL_BROWN_BIT];
    end
  end

  // Read data
  always @(posedge clk)
  begin
    if (!rst_b)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      if (hit(paddr, `PWRCTL_OFFSET))
        prdata <= {30'h00000000, powerFlag_r, brownFlag_r};
      else if (hit(paddr, `SEQCFG_OFFSET))
        prdata <= {28'h0000000, cfg_r};
      else if (hit(paddr, `SEQSTAT_OFFSET))
        prdata <= {28'h0000000, internalReset, pinLvl_r, state_r};
      else
        prdata <= 32'h00000000;
    end
  end

endmodule

// >>> reset_seq_sva.sv
// Checker for the reset time-out sequencer ports
`timescale 1ns/1ns
module reset_seq_sva (
  // Clock, reset and reset sources
  input wire        clk, rst_b, powerOnPulse, brownoutPulse, extResetPin_b,
  // APB and sequencer outputs
  input wire        psel, penable, pwrite, pready, pslverr, internalReset, seqBusy,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Read access phase
  wire rd = psel && penable && !pwrite;
  property p_rdy; pready && !pslverr; endproperty
  a_rdy: assert property (p_rdy) else $error("bus answer bad");
  property p_pwr; rd && paddr == 12'h238 |-> prdata[31:2] == 30'h0; endproperty
  a_pwr: assert property (p_pwr) else $error("power reg high bits");
  property p_gap; rd && paddr > 12'h094 && paddr != 12'h238 |-> prdata == 32'h0; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read");
  property p_por; powerOnPulse [*6] |=> internalReset; endproperty
  a_por: assert property (p_por) else $error("reset not held");
  property p_pin; !extResetPin_b [*6] |=> internalReset; endproperty
  a_pin: assert property (p_pin) else $error("pin not held");
  property p_busy; seqBusy |-> internalReset; endproperty
  a_busy: assert property (p_busy) else $error("busy released");
  property p_one; $fell(powerOnPulse) |-> internalReset [*3]; endproperty
  a_one: assert property (p_one) else $error("early release");
  property p_fast;
    $rose(extResetPin_b) && !seqBusy && !powerOnPulse |-> ##[1:6] !internalReset;
  endproperty
  a_fast: assert property (p_fast) else $error("late pin release");
  c_rd: cover property (rd);
  c_bo: cover property ($rose(brownoutPulse));
  c_go: cover property ($fell(internalReset));
endmodule

// >>> reset_timeout_sequencer_tb_top.sv
// Testbench for the reset time-out sequencer
`timescale 1ns/1ns
module reset_timeout_sequencer_tb_top;
  reg clk = 0, rst_b = 0, powerOnPulse = 1, brownoutPulse = 0, extResetPin_b = 1;
  reg psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0, seed = 32'h2B6260D4, d;
  wire pready, pslverr, internalReset, seqBusy;
  wire [31:0] prdata;
  reg [31:0] expQ[$];
  integer n_errors = 0, samples_checked = 0, t, t0, i;
  reset_timeout_sequencer #(.DELAY_CYCLES(8), .OSC_CYCLES(4)) dut_u (.clk(clk),
    .rst_b(rst_b), .powerOnPulse(powerOnPulse), .brownoutPulse(brownoutPulse),
    .extResetPin_b(extResetPin_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .internalReset(internalReset), .seqBusy(seqBusy));
  initial forever #10 clk = ~clk;
  task print_verdict;
  begin
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  end
  endtask
  // Common compare core: counts every check, reports a mismatch
  task cmp(input [8*16:1] nm, input [31:0] e, input [31:0] s);
  begin
    samples_checked = samples_checked + 1;
    if (e !== s)
    begin
      n_errors = n_errors + 1;
      $display("wrong value %0s exp %h seen %h", nm, e, s);
    end
  end
  endtask
  // One compare task per kind of result
  task cmp_data(input [31:0] e, input [31:0] s);
    cmp("read data", e, s);
  endtask
  task cmp_level(input [31:0] e, input [31:0] s);
    cmp("internal reset", e, s);
  endtask
  task cmp_cycles(input [31:0] e, input [31:0] s);
    cmp("cycle count", e, s);
  endtask
  // One APB transfer: setup, access held until pready, then an idle edge
  task apb(input w, input [11:0] a, input [31:0] v);
    integer j;
  begin
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    for (j = 0; j < 9 && pready !== 1'b1; j = j + 1) @(posedge clk);
    if (j == 9)
    begin
      n_errors = n_errors + 1;
      print_verdict;
    end
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  end
  endtask
  task rd(input [11:0] a, input [31:0] e); begin expQ.push_back(e); apb(0, a, 0); end endtask
  // Monitor takes the oldest note whenever read data is presented
  always @(posedge clk)
  begin
    if (psel && penable && !pwrite && pready)
    begin
      if (expQ.size() == 0)
        n_errors = n_errors + 1;
      else
        cmp_data(expQ.pop_front(), prdata);
    end
  end
  // Power-on pulse held six cycles
  task pulse;
  begin
    powerOnPulse <= 1;
    repeat (6) @(posedge clk);
    powerOnPulse <= 0;
  end
  endtask
  // Cycles until internal reset is released, bounded
  task rel(output integer n);
  begin
    for (n = 0; n < 99 && internalReset !== 1'b0; n = n + 1) @(posedge clk);
    if (n == 99)
    begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    cmp_level(1, internalReset);
    // External clock alone, delay plus oscillator, oscillator alone
    for (i = 0; i < 3; i = i + 1)
    begin
      apb(1, 12'h090, i == 0 ? 8 : i);
      pulse;
      rel(t);
      if (i == 0)
      begin
        t0 = t;
        cmp_cycles(1, t0 >= 4 && t0 <= 7);
      end
      else
        cmp_cycles(i == 1 ? 12 : 4, t - t0);
    end
    $display("chain timing done");
    extResetPin_b <= 0;
    pulse;
    repeat (40) @(posedge clk);
    cmp_level(1, internalReset);
    extResetPin_b <= 1;
    rel(t);
    cmp_cycles(1, t <= 6);
    $display("late pin done");
    apb(1, 12'h238, 3);
    rd(12'h238, 3);
    pulse;
    rel(t);
    rd(12'h238, 1);
    apb(1, 12'h090, 2);
    apb(1, 12'h238, 3);
    brownoutPulse <= 1;
    repeat (6) @(posedge clk);
    brownoutPulse <= 0;
    rel(t);
    rd(12'h238, 2);
    d = $random(seed);
    apb(1, 12'h238, d);
    rd(12'h238, d & 3);
    apb(1, 12'hFFC, $random(seed));
    rd(12'hFFC, 0);
    $display("flags done");
    // Reset again in mid-run: reset held, flags cleared, chain restarts
    rst_b <= 0;
    repeat (5) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    cmp_level(1, internalReset);
    rd(12'h238, 0);
    rel(t);
    cmp_cycles(1, t > 0);
    $display("reset restart done");
    print_verdict;
  end
endmodule
bind reset_timeout_sequencer reset_seq_sva chk_u (.clk(clk), .rst_b(rst_b),
  .powerOnPulse(powerOnPulse), .brownoutPulse(brownoutPulse), .extResetPin_b(extResetPin_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .internalReset(internalReset), .seqBusy(seqBusy), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata));
